/* common/loop_master_cfg.svh */
// Constants for the loop master signaling controller
// What this block does
// - Loopback isolates line input, holds drivers, loops internally
// - Loopback acts only while powered on
// - Valid frame only with good sync, no errors
// - Valid frame updates on sync edge or demod end
// - Signaling inputs sampled on frame sync rise
// - Signaling outputs update on sync edge or demod end
// - Share disable latches controls, floats status outputs
// - Powered down: no modulation, demod and outputs live
// - Powered down: no transmit or receive register transfers
// - Power-up waits three syncs or slave burst end
// - Each frame sync from the arming sync on starts one modulation burst
// - Insert mode puts slave bit 2 into output LSB
// - Insert mode sends input PCM LSB as bit 2
// - Insert mode forces sent PCM word LSB low
// - Tx gate shifts eight bits out, else float
// - Rx gate loads eight bits on falling edges
`ifndef LOOP_MASTER_CFG_SVH
`define LOOP_MASTER_CFG_SVH

// Register byte offsets
`define REG_STATUS 8'h00
`define REG_MASK 8'h04
`define REG_CTRL 8'h08
`define REG_STATE 8'h0C

// Status and mask bit positions
`define EV_FRAME_SYNC 0
`define EV_DEMOD_DONE 1
`define EV_VALID_LOST 2
`define EV_POWER_UP 3
`define EV_COUNT 4

// Control bits and reset value
`define CTRL_MOD_EN 0
`define CTRL_RESET 8'h01

// Synchronised pin vector positions
`define PIN_FSYNC 0
`define PIN_PCLK 1
`define PIN_TXG 2
`define PIN_RXG 3
`define PIN_PCMIN 4
`define PIN_SIGA 5
`define PIN_SIGB 6
`define PIN_PWR 7
`define PIN_LOOPN 8
`define PIN_INSERT 9
`define PIN_SHARE 10
`define PIN_COUNT 11

// Sync edges to wait after power-up, PCM word length
`define POWERUP_SYNC_EDGES 2'h3
`define PCM_BITS 4'h8

// AXI responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

/* common/loop_master_pkg.sv */
// Types shared by the loop master signaling controller
package loop_master_pkg;

	// Power sequencing states
	typedef enum logic [1:0] {
		PWR_DOWN,
		PWR_WAIT,
		PWR_ARMED,
		PWR_RUN
	} pwr_state_type;

	// Register selected by an address
	typedef enum logic [2:0] {
		SEL_STATUS,
		SEL_MASK,
		SEL_CTRL,
		SEL_STATE,
		SEL_NONE
	} reg_sel_type;

endpackage

/* design/pin_sync.sv */
// Two-flop synchroniser with edge detection for a bundle of pins
`timescale 1ns/1ns
`default_nettype none

module pin_sync #(
	parameter int W = 1
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [W-1:0] din,
	output logic [W-1:0] q,
	output logic [W-1:0] rise,
	output logic [W-1:0] fall
);

	logic [W-1:0] meta_reg; // First stage, read only by the second
	logic [W-1:0] sync_reg; // Second stage, safe to use
	logic [W-1:0] last_reg; // Previous synced value for edges

	// Shift chain; edges come from stages two and three only
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			meta_reg <= '0;
			sync_reg <= '0;
			last_reg <= '0;
		end else begin
			meta_reg <= din;
			sync_reg <= meta_reg;
			last_reg <= sync_reg;
		end
	end

	assign q = sync_reg;
	assign rise = sync_reg & ~last_reg;
	assign fall = ~sync_reg & last_reg;

endmodule

`default_nettype wire

/* design/loop_master_signaling_ctrl.sv */
// Master-side signaling, power and PCM control of a digital-loop transceiver
//
// Decided for this implementation: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ns
`default_nettype none
`include "loop_master_cfg.svh"

module loop_master_signaling_ctrl #(
	parameter int ADDR_W = 8
) (
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite slave
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic irq,
	// Device pins
	input wire logic frame_sync_in,
	input wire logic pcm_bit_clock,
	input wire logic tx_gate,
	input wire logic rx_gate,
	input wire logic pcm_in,
	output logic pcm_out,
	output logic pcm_out_oe,
	input wire logic sig_in_a,
	input wire logic sig_in_b,
	output logic sig_out_a,
	output logic sig_out_a_oe,
	output logic sig_out_b,
	output logic sig_out_b_oe,
	output logic valid_frame,
	output logic valid_frame_oe,
	input wire logic power_on,
	input wire logic self_loop_n,
	input wire logic sig_lsb_insert_en,
	input wire logic bus_share_en,
	// Line front end control
	output logic demod_input_en,
	output logic drive_ref_hold,
	output logic loop_internal,
	output logic modulator_on,
	// Demodulator results, same clock
	input wire logic demod_done,
	input wire logic demod_sync_ok,
	input wire logic demod_bit_err,
	input wire logic [7:0] demod_pcm,
	input wire logic demod_sig_a,
	input wire logic demod_sig_b,
	// Modulator burst request
	output logic burst_start,
	output logic [7:0] burst_pcm,
	output logic burst_sig_a,
	output logic burst_sig_b
);

	// Decode a register address; shared by read and write paths
	function automatic loop_master_pkg::reg_sel_type reg_decode(input logic [ADDR_W-1:0] a);
		logic [7:0] lo;
		lo = a[7:0];
		if ((a >> 8) != '0) begin
			reg_decode = loop_master_pkg::SEL_NONE;
		end else if (lo == `REG_STATUS) begin
			reg_decode = loop_master_pkg::SEL_STATUS;
		end else if (lo == `REG_MASK) begin
			reg_decode = loop_master_pkg::SEL_MASK;
		end else if (lo == `REG_CTRL) begin
			reg_decode = loop_master_pkg::SEL_CTRL;
		end else if (lo == `REG_STATE) begin
			reg_decode = loop_master_pkg::SEL_STATE;
		end else begin
			reg_decode = loop_master_pkg::SEL_NONE;
		end
	endfunction

	// Pin synchronisation: every pin is asynchronous to aclk
	logic [`PIN_COUNT-1:0] pin_raw;
	logic [`PIN_COUNT-1:0] pin_q;
	logic [`PIN_COUNT-1:0] pin_rise;
	logic [`PIN_COUNT-1:0] pin_fall;

	assign pin_raw = {bus_share_en, sig_lsb_insert_en, self_loop_n, power_on, sig_in_b,
		sig_in_a, pcm_in, rx_gate, tx_gate, pcm_bit_clock, frame_sync_in};

	pin_sync #(.W(`PIN_COUNT)) u_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.din(pin_raw),
		.q(pin_q),
		.rise(pin_rise),
		.fall(pin_fall)
	);

	wire share_on = pin_q[`PIN_SHARE];
	wire fs_rise = pin_rise[`PIN_FSYNC];
	wire pclk_rise = pin_rise[`PIN_PCLK];
	wire pclk_fall = pin_fall[`PIN_PCLK];

	// Held copies of the shared control inputs
	logic [4:0] held_reg; // {insert, loop_n, power, sig_b, sig_a}
	wire [4:0] live_ctl = {pin_q[`PIN_INSERT], pin_q[`PIN_LOOPN], pin_q[`PIN_PWR],
		pin_q[`PIN_SIGB], pin_q[`PIN_SIGA]};
	// Live pins while shared bus enabled, frozen copy otherwise
	wire [4:0] eff_ctl = share_on ? live_ctl : held_reg;
	wire eff_sig_a = eff_ctl[0];
	wire eff_sig_b = eff_ctl[1];
	wire eff_power = eff_ctl[2];
	wire eff_loop_n = eff_ctl[3];
	wire eff_insert = eff_ctl[4];

	// Track the pins while enabled so the value at the fall is kept
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			held_reg <= 5'h00;
		end else if (share_on) begin
			held_reg <= live_ctl;
		end
	end

	// Loopback front end control
	wire loop_active = eff_power & ~eff_loop_n;
	assign demod_input_en = ~loop_active;
	assign drive_ref_hold = loop_active;
	assign loop_internal = loop_active;
	assign modulator_on = eff_power;

	// Register file state
	logic [`EV_COUNT-1:0] status_reg; // Sticky events
	logic [`EV_COUNT-1:0] mask_reg; // Interrupt enables
	logic [7:0] ctrl_reg; // Control bits
	wire mod_en = ctrl_reg[`CTRL_MOD_EN];

	// Power sequencing
	loop_master_pkg::pwr_state_type pwr_reg;
	loop_master_pkg::pwr_state_type pwr_next;
	logic [1:0] wait_cnt_reg; // Frame sync edges seen while waiting
	logic [1:0] wait_cnt_next;
	wire wait_done = (wait_cnt_reg + 2'h1 == `POWERUP_SYNC_EDGES) & fs_rise;

	// Next power state
	always_comb begin
		pwr_next = pwr_reg;
		wait_cnt_next = wait_cnt_reg;
		case (pwr_reg)
			loop_master_pkg::PWR_DOWN: begin
				wait_cnt_next = 2'h0;
				if (eff_power) begin
					pwr_next = loop_master_pkg::PWR_WAIT;
				end
			end
			loop_master_pkg::PWR_WAIT: begin
				// Three syncs or the end of a slave burst, whichever first
				if (wait_done || demod_done) begin
					pwr_next = loop_master_pkg::PWR_ARMED;
				end else if (fs_rise) begin
					wait_cnt_next = wait_cnt_reg + 2'h1;
				end
			end
			loop_master_pkg::PWR_ARMED: begin
				if (fs_rise) begin
					pwr_next = loop_master_pkg::PWR_RUN;
				end
			end
			default: begin
				pwr_next = pwr_reg;
			end
		endcase
		// Power loss overrides every state
		if (!eff_power) begin
			pwr_next = loop_master_pkg::PWR_DOWN;
		end
	end

	// Power state registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pwr_reg <= loop_master_pkg::PWR_DOWN;
			wait_cnt_reg <= 2'h0;
		end else begin
			pwr_reg <= pwr_next;
			wait_cnt_reg <= wait_cnt_next;
		end
	end

	// A burst starts on each sync once running, and on the arming sync
	wire transmitting = (pwr_reg == loop_master_pkg::PWR_RUN) ||
		(pwr_reg == loop_master_pkg::PWR_ARMED);
	wire burst_go = fs_rise & transmitting & eff_power & mod_en;
	wire power_up_ev = fs_rise & eff_power & (pwr_reg == loop_master_pkg::PWR_ARMED);

	// PCM receive shift: eight falling bit-clock edges after rx gate rise
	logic [7:0] rx_shift_reg;
	logic [3:0] rx_cnt_reg; // Bits still to take
	logic [7:0] rx_word_reg; // Word heading for the slave
	wire rx_take = pclk_fall & (rx_cnt_reg != 4'h0);
	wire rx_last = rx_take & (rx_cnt_reg == 4'h1);

	// Receive shifter, MSB first
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rx_shift_reg <= 8'h00;
			rx_cnt_reg <= 4'h0;
		end else if (pin_rise[`PIN_RXG]) begin
			rx_cnt_reg <= `PCM_BITS;
		end else if (rx_take) begin
			rx_shift_reg <= {rx_shift_reg[6:0], pin_q[`PIN_PCMIN]};
			rx_cnt_reg <= rx_cnt_reg - 4'h1;
		end
	end

	// Word transfer stops in power-down
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rx_word_reg <= 8'h00;
		end else if (rx_last && eff_power) begin
			rx_word_reg <= {rx_shift_reg[6:0], pin_q[`PIN_PCMIN]};
		end
	end

	// Demodulated results held until the next frame sync
	logic valid_pend_reg;
	logic sig_a_pend_reg;
	logic sig_b_pend_reg;
	logic [7:0] line_pcm_reg; // Last word received from the slave
	wire frame_good = demod_sync_ok & ~demod_bit_err;

	// Catch each demodulated burst; a new burst wins over the sync clear
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			valid_pend_reg <= 1'b0;
			sig_a_pend_reg <= 1'b0;
			sig_b_pend_reg <= 1'b0;
			line_pcm_reg <= 8'h00;
		end else if (demod_done) begin
			valid_pend_reg <= frame_good;
			sig_a_pend_reg <= demod_sig_a;
			sig_b_pend_reg <= demod_sig_b;
			line_pcm_reg <= demod_pcm;
		end else if (fs_rise && eff_power) begin
			// No burst this frame reads as invalid next frame
			valid_pend_reg <= 1'b0;
		end
	end

	// Status outputs: sync edge when powered, demod end when down
	logic valid_frame_reg;
	logic sig_out_a_reg;
	logic sig_out_b_reg;
	wire out_update = eff_power ? fs_rise : demod_done;
	wire out_valid = eff_power ? valid_pend_reg : frame_good;
	wire valid_lost = out_update & valid_frame_reg & ~out_valid;

	// Status output registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			valid_frame_reg <= 1'b0;
			sig_out_a_reg <= 1'b0;
			sig_out_b_reg <= 1'b0;
		end else if (out_update) begin
			valid_frame_reg <= out_valid;
			sig_out_a_reg <= eff_power ? sig_a_pend_reg : demod_sig_a;
			sig_out_b_reg <= eff_power ? sig_b_pend_reg : demod_sig_b;
		end
	end

	// Outputs float while the shared bus is given away
	assign valid_frame = valid_frame_reg;
	assign sig_out_a = sig_out_a_reg;
	assign sig_out_b = sig_out_b_reg;
	assign valid_frame_oe = share_on;
	assign sig_out_a_oe = share_on;
	assign sig_out_b_oe = share_on;

	// Burst contents, sampled at the sync that starts the burst
	logic [7:0] burst_pcm_reg;
	logic burst_sig_a_reg;
	logic burst_sig_b_reg;
	logic burst_start_reg;
	// Insert mode: bit 2 rides in the PCM LSB, which then goes out as zero
	wire [7:0] send_pcm = eff_insert ? {rx_word_reg[7:1], 1'b0} : rx_word_reg;
	wire send_sig_b = eff_insert ? rx_word_reg[0] : eff_sig_b;

	// Load the burst payload on each frame sync rise while powered
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			burst_pcm_reg <= 8'h00;
			burst_sig_a_reg <= 1'b0;
			burst_sig_b_reg <= 1'b0;
			burst_start_reg <= 1'b0;
		end else begin
			burst_start_reg <= burst_go;
			if (fs_rise && eff_power) begin
				burst_pcm_reg <= send_pcm;
				burst_sig_a_reg <= eff_sig_a;
				burst_sig_b_reg <= send_sig_b;
			end
		end
	end

	assign burst_start = burst_start_reg;
	assign burst_pcm = burst_pcm_reg;
	assign burst_sig_a = burst_sig_a_reg;
	assign burst_sig_b = burst_sig_b_reg;

	// Transmit word and shifter
	logic [7:0] tx_word_reg;
	logic [3:0] tx_cnt_reg; // Bits already presented
	logic pcm_out_reg;
	wire tx_gate_on = pin_q[`PIN_TXG];
	wire [7:0] tx_src = eff_insert ? {line_pcm_reg[7:1], sig_b_pend_reg} : line_pcm_reg;

	// Slave word moves to the output register on the frame sync
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tx_word_reg <= 8'h00;
		end else if (fs_rise && eff_power) begin
			tx_word_reg <= tx_src;
		end
	end

	// One bit per rising bit-clock edge, MSB first, eight in all
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tx_cnt_reg <= 4'h0;
			pcm_out_reg <= 1'b0;
		end else if (pin_rise[`PIN_TXG]) begin
			tx_cnt_reg <= 4'h0;
		end else if (tx_gate_on && pclk_rise && tx_cnt_reg != `PCM_BITS) begin
			pcm_out_reg <= tx_word_reg[3'(4'h7 - tx_cnt_reg)];
			tx_cnt_reg <= tx_cnt_reg + 4'h1;
		end
	end

	assign pcm_out = pcm_out_reg;
	assign pcm_out_oe = tx_gate_on;

	// Event sources
	logic [`EV_COUNT-1:0] ev_set;
	assign ev_set[`EV_FRAME_SYNC] = fs_rise;
	assign ev_set[`EV_DEMOD_DONE] = demod_done;
	assign ev_set[`EV_VALID_LOST] = valid_lost;
	assign ev_set[`EV_POWER_UP] = power_up_ev;

	// AXI4-Lite write path: address and data may come in either order
	logic aw_full_reg;
	logic w_full_reg;
	logic [ADDR_W-1:0] aw_addr_reg;
	logic [31:0] w_data_reg;
	logic [3:0] w_strb_reg;
	logic bvalid_reg;
	logic [1:0] bresp_reg;
	assign s_axi_awready = ~aw_full_reg & ~bvalid_reg;
	assign s_axi_wready = ~w_full_reg & ~bvalid_reg;
	wire do_write = aw_full_reg & w_full_reg & ~bvalid_reg;
	wire loop_master_pkg::reg_sel_type wsel = reg_decode(aw_addr_reg);
	wire wlow = do_write & w_strb_reg[0]; // All fields sit in byte 0
	wire [`EV_COUNT-1:0] w1c = (wlow && wsel == loop_master_pkg::SEL_STATUS) ?
		w_data_reg[`EV_COUNT-1:0] : '0;

	// Capture halves, then answer once both are in
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_full_reg <= 1'b0;
			w_full_reg <= 1'b0;
			aw_addr_reg <= '0;
			w_data_reg <= 32'h00000000;
			w_strb_reg <= 4'h0;
			bvalid_reg <= 1'b0;
			bresp_reg <= `RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_full_reg <= 1'b1;
				aw_addr_reg <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_full_reg <= 1'b1;
				w_data_reg <= s_axi_wdata;
				w_strb_reg <= s_axi_wstrb;
			end
			if (do_write) begin
				aw_full_reg <= 1'b0;
				w_full_reg <= 1'b0;
				bvalid_reg <= 1'b1;
				bresp_reg <= (wsel == loop_master_pkg::SEL_NONE) ? `RESP_SLVERR : `RESP_OKAY;
			end else if (bvalid_reg && s_axi_bready) begin
				bvalid_reg <= 1'b0;
			end
		end
	end

	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;

	// Status, mask and control; a new event beats a write-one clear
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			status_reg <= '0;
			mask_reg <= '0;
			ctrl_reg <= `CTRL_RESET;
		end else begin
			status_reg <= (status_reg & ~w1c) | ev_set;
			if (wlow && wsel == loop_master_pkg::SEL_MASK) begin
				mask_reg <= w_data_reg[`EV_COUNT-1:0];
			end
			if (wlow && wsel == loop_master_pkg::SEL_CTRL) begin
				ctrl_reg <= {7'h00, w_data_reg[`CTRL_MOD_EN]};
			end
		end
	end

	assign irq = |(status_reg & mask_reg);

	// AXI4-Lite read path, one outstanding read
	logic rvalid_reg;
	logic [31:0] rdata_reg;
	logic [1:0] rresp_reg;
	assign s_axi_arready = ~rvalid_reg;
	wire loop_master_pkg::reg_sel_type rsel = reg_decode(s_axi_araddr);
	wire [31:0] state_word = {24'h000000, pwr_reg, share_on, sig_out_b_reg, sig_out_a_reg,
		valid_frame_reg, loop_active, eff_power};
	wire [31:0] rd_mux =
		(rsel == loop_master_pkg::SEL_STATUS) ? {28'h0000000, status_reg} :
		(rsel == loop_master_pkg::SEL_MASK) ? {28'h0000000, mask_reg} :
		(rsel == loop_master_pkg::SEL_CTRL) ? {24'h000000, ctrl_reg} :
		(rsel == loop_master_pkg::SEL_STATE) ? state_word : 32'h00000000;

	// Read data is captured at the address handshake
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_reg <= 1'b0;
			rdata_reg <= 32'h00000000;
			rresp_reg <= `RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			rvalid_reg <= 1'b1;
			rdata_reg <= rd_mux;
			rresp_reg <= (rsel == loop_master_pkg::SEL_NONE) ? `RESP_SLVERR : `RESP_OKAY;
		end else if (rvalid_reg && s_axi_rready) begin
			rvalid_reg <= 1'b0;
		end
	end

	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rdata = rdata_reg;
	assign s_axi_rresp = rresp_reg;

endmodule

`default_nettype wire

/* bench/loop_master_monitor.sv */
// Port-level assertions for the loop master signaling controller
`timescale 1ns/1ns
`default_nettype none

module loop_master_monitor (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic bus_share_en,
	input wire logic power_on,
	input wire logic self_loop_n,
	input wire logic tx_gate,
	input wire logic sig_out_a,
	input wire logic sig_out_b,
	input wire logic sig_out_a_oe,
	input wire logic sig_out_b_oe,
	input wire logic valid_frame,
	input wire logic valid_frame_oe,
	input wire logic pcm_out_oe,
	input wire logic demod_input_en,
	input wire logic drive_ref_hold,
	input wire logic loop_internal,
	input wire logic modulator_on,
	input wire logic burst_start,
	input wire logic demod_done,
	input wire logic demod_sync_ok,
	input wire logic demod_bit_err,
	input wire logic demod_sig_a,
	input wire logic demod_sig_b
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	// Pins settle through the synchroniser before effects are due
	sequence s_share_off;
		!bus_share_en [*4];
	endsequence
	sequence s_share_on;
		bus_share_en [*4];
	endsequence
	sequence s_demod_down;
		demod_done && !modulator_on;
	endsequence
	chk_loop_drive: assert property ((!self_loop_n && power_on && bus_share_en) [*4] |->
		loop_internal && drive_ref_hold && !demod_input_en) else $error("loopback not applied");
	chk_loop_power: assert property ((!power_on && bus_share_en) [*4] |->
		!loop_internal && demod_input_en && !modulator_on) else $error("loop or modulator on");
	chk_share_float: assert property (s_share_off |->
		!valid_frame_oe && !sig_out_a_oe && !sig_out_b_oe) else $error("status pins driven");
	chk_share_drive: assert property (s_share_on |->
		valid_frame_oe && sig_out_a_oe && sig_out_b_oe) else $error("status pins floating");
	chk_tx_float: assert property (!tx_gate [*3] |-> !pcm_out_oe)
		else $error("pcm output driven without gate");
	chk_tx_drive: assert property (tx_gate [*4] |-> pcm_out_oe)
		else $error("pcm output floating under gate");
	chk_burst_pulse: assert property (burst_start |=> !burst_start)
		else $error("burst start longer than a cycle");
	chk_down_quiet: assert property (!modulator_on [*2] |-> !burst_start)
		else $error("burst while powered down");
	chk_powerup_wait: assert property ($rose(modulator_on) |-> !burst_start [*6])
		else $error("burst too soon after power up");
	chk_pd_signal: assert property (s_demod_down |=> sig_out_a == $past(demod_sig_a)
		&& sig_out_b == $past(demod_sig_b)) else $error("signaling not updated");
	chk_pd_valid: assert property (s_demod_down |=> valid_frame ==
		($past(demod_sync_ok) && !$past(demod_bit_err))) else $error("valid flag wrong");
endmodule

bind loop_master_signaling_ctrl loop_master_monitor i_loop_master_monitor (
	.aclk, .aresetn, .bus_share_en, .power_on, .self_loop_n, .tx_gate, .sig_out_a,
	.sig_out_b, .sig_out_a_oe, .sig_out_b_oe, .valid_frame, .valid_frame_oe, .pcm_out_oe,
	.demod_input_en, .drive_ref_hold, .loop_internal, .modulator_on, .burst_start,
	.demod_done, .demod_sync_ok, .demod_bit_err, .demod_sig_a, .demod_sig_b
);

`default_nettype wire

/* bench/slave_model.sv */
// Behavioural remote slave: answers each burst with a demodulated frame
`timescale 1ns/1ns
`default_nettype none

module slave_model (
	input wire logic aclk,
	input wire logic burst_start,
	input wire logic unsolicited,
	input wire logic bad_frame,
	input wire logic [7:0] slv_word,
	input wire logic slv_a,
	input wire logic slv_b,
	output logic demod_done,
	output logic demod_sync_ok,
	output logic demod_bit_err,
	output logic [7:0] demod_pcm,
	output logic demod_sig_a,
	output logic demod_sig_b
);
	// Reply after a fixed line delay; lines scramble when idle
	initial begin
		demod_done = 1'h0;
		demod_sync_ok = 1'h0;
		demod_bit_err = 1'h0;
		demod_pcm = 8'h00;
		demod_sig_a = 1'h0;
		demod_sig_b = 1'h0;
		forever begin
			@(posedge aclk);
			if (burst_start || unsolicited) begin
				repeat (5) @(posedge aclk);
				demod_done <= 1'h1;
				demod_sync_ok <= 1'h1;
				demod_bit_err <= bad_frame;
				demod_pcm <= slv_word;
				demod_sig_a <= slv_a;
				demod_sig_b <= slv_b;
				@(posedge aclk);
				demod_done <= 1'h0;
				demod_sync_ok <= 1'h0;
				demod_pcm <= ~slv_word;
				demod_sig_a <= ~slv_a;
				demod_sig_b <= ~slv_b;
			end
		end
	end
endmodule

`default_nettype wire

/* bench/tb.sv */
// Self-checking testbench for the loop master signaling controller
`timescale 1ns/1ns
`default_nettype none

module tb;
	logic aclk = 1'h0;
	logic aresetn = 1'h0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, slv_word = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0;
	logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	logic frame_sync_in = 1'h0, pcm_bit_clock = 1'h0, tx_gate = 1'h0, rx_gate = 1'h0;
	logic pcm_in = 1'h0, sig_in_a = 1'h0, sig_in_b = 1'h0, power_on = 1'h0;
	logic self_loop_n = 1'h1, sig_lsb_insert_en = 1'h0, bus_share_en = 1'h1;
	logic unsolicited = 1'h0, bad_frame = 1'h0, slv_a = 1'h0, slv_b = 1'h0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	logic pcm_out, pcm_out_oe, sig_out_a, sig_out_a_oe, sig_out_b, sig_out_b_oe;
	logic valid_frame, valid_frame_oe, demod_input_en, drive_ref_hold, loop_internal;
	logic modulator_on, demod_done, demod_sync_ok, demod_bit_err, demod_sig_a, demod_sig_b;
	logic burst_start, burst_sig_a, burst_sig_b;
	logic [7:0] demod_pcm, burst_pcm;
	int mismatches = 0;
	int n_tests = 0;
	int bursts = 0; // Burst starts seen since reset

	loop_master_signaling_ctrl i_loop_master_signaling_ctrl (
		.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq, .frame_sync_in, .pcm_bit_clock,
		.tx_gate, .rx_gate, .pcm_in, .pcm_out, .pcm_out_oe, .sig_in_a, .sig_in_b, .sig_out_a,
		.sig_out_a_oe, .sig_out_b, .sig_out_b_oe, .valid_frame, .valid_frame_oe, .power_on,
		.self_loop_n, .sig_lsb_insert_en, .bus_share_en, .demod_input_en, .drive_ref_hold,
		.loop_internal, .modulator_on, .demod_done, .demod_sync_ok, .demod_bit_err,
		.demod_pcm, .demod_sig_a, .demod_sig_b, .burst_start, .burst_pcm, .burst_sig_a,
		.burst_sig_b
	);

	slave_model i_slave_model (
		.aclk, .burst_start, .unsolicited, .bad_frame, .slv_word, .slv_a, .slv_b,
		.demod_done, .demod_sync_ok, .demod_bit_err, .demod_pcm, .demod_sig_a, .demod_sig_b
	);

	// Free-running 100 MHz clock
	initial begin
		forever #5 aclk = ~aclk;
	end

	// Count modulation bursts requested by the block
	always @(posedge aclk) begin
		if (burst_start === 1'h1) bursts++;
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			mismatches++;
			$display("[FAIL] %0t got %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge aclk);
	endtask

	// Write: address and data offered together, each released when taken
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		logic aw, w;
		aw = 1'h1;
		w = 1'h1;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		while (aw || w) begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wready) s_axi_wvalid <= 1'h0;
			aw = aw && !s_axi_awready;
			w = w && !s_axi_wready;
		end
		while (!s_axi_bvalid) @(posedge aclk);
		check(s_axi_bresp, r);
		s_axi_bready <= 1'h0;
		@(posedge aclk);
	endtask

	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] r);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do @(posedge aclk); while (!s_axi_arready);
		s_axi_arvalid <= 1'h0;
		while (!s_axi_rvalid) @(posedge aclk);
		d = s_axi_rdata;
		check(s_axi_rresp, r);
		s_axi_rready <= 1'h0;
		@(posedge aclk);
	endtask

	// One frame: sync pulse, then room for the slave reply
	task automatic sync;
		frame_sync_in <= 1'h1;
		pcm_bit_clock <= 1'h1;
		cyc(6);
		frame_sync_in <= 1'h0;
		pcm_bit_clock <= 1'h0;
		cyc(10);
	endtask

	task automatic pclk;
		pcm_bit_clock <= 1'h1;
		cyc(6);
		pcm_bit_clock <= 1'h0;
		cyc(6);
	endtask

	task automatic slave_burst;
		unsolicited <= 1'h1;
		@(posedge aclk);
		unsolicited <= 1'h0;
		cyc(10);
	endtask

	task automatic t_regs;
		logic [31:0] d;
		axi_rd(8'h08, d, 2'h0);
		check(d, 32'h1);
		axi_rd(8'h0C, d, 2'h0);
		check(d, 32'h20);
		axi_rd(8'h10, d, 2'h2);
		check(d, 32'h0);
		axi_wr(8'h10, 32'h1, 2'h2);
	endtask

	// Powered down: slave frames update outputs at once, interrupt flow
	task automatic t_pd_rx;
		axi_wr(8'h04, 32'h2, 2'h0);
		slv_a <= 1'h1;
		slv_b <= 1'h1;
		slave_burst();
		check(sig_out_a, 1'h1);
		check(sig_out_b, 1'h1);
		check(valid_frame, 1'h1);
		check(irq, 1'h1);
		axi_wr(8'h00, 32'h2, 2'h0);
		check(irq, 1'h0);
		axi_wr(8'h04, 32'h0, 2'h0);
		bad_frame <= 1'h1;
		slave_burst();
		check(valid_frame, 1'h0);
		check(irq, 1'h0);
		check(bursts, 0);
		bad_frame <= 1'h0;
	endtask

	task automatic t_powerup;
		slv_a <= 1'h0;
		sig_in_a <= 1'h1;
		power_on <= 1'h1;
		cyc(4);
		repeat (3) sync();
		check(bursts, 0);
		sync();
		check(bursts, 1);
		check(burst_sig_a, 1'h1);
		check(burst_sig_b, 1'h0);
		sync();
		check(bursts, 2);
		check(sig_out_a, 1'h0);
		check(sig_out_b, 1'h1);
		check(valid_frame, 1'h1);
	endtask

	// Insert mode: PCM in, bursts out, then PCM word shifted out
	task automatic t_pcm;
		logic [7:0] w;
		w = 8'hA5;
		sig_lsb_insert_en <= 1'h1;
		slv_word <= 8'h3C;
		rx_gate <= 1'h1;
		cyc(6);
		for (int i = 7; i >= 0; i--) begin
			pcm_in <= w[i];
			pclk();
		end
		rx_gate <= 1'h0;
		sync();
		check(burst_pcm, 8'hA4);
		check(burst_sig_b, 1'h1);
		sync();
		w = 8'h3D;
		tx_gate <= 1'h1;
		cyc(6);
		for (int i = 7; i >= 0; i--) begin
			pclk();
			check(pcm_out, w[i]);
		end
		check(pcm_out_oe, 1'h1);
		tx_gate <= 1'h0;
		cyc(4);
		check(pcm_out_oe, 1'h0);
		sig_lsb_insert_en <= 1'h0;
	endtask

	// Shared bus: controls held at the fall, live again when raised
	task automatic t_share;
		bus_share_en <= 1'h0;
		cyc(4);
		check(valid_frame_oe, 1'h0);
		check(sig_out_a_oe, 1'h0);
		sig_in_a <= 1'h0;
		power_on <= 1'h0;
		sync();
		check(burst_sig_a, 1'h1);
		check(bursts, 5);
		bus_share_en <= 1'h1;
		cyc(4);
		check(sig_out_b_oe, 1'h1);
		sync();
		check(bursts, 5);
		check(modulator_on, 1'h0);
	endtask

	task automatic t_loop;
		power_on <= 1'h1;
		self_loop_n <= 1'h0;
		cyc(5);
		check(loop_internal, 1'h1);
		check(drive_ref_hold, 1'h1);
		check(demod_input_en, 1'h0);
		power_on <= 1'h0;
		cyc(5);
		check(loop_internal, 1'h0);
		check(demod_input_en, 1'h1);
		self_loop_n <= 1'h1;
	endtask

	task automatic finish_test;
		if (mismatches == 0 && n_tests > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// Main sequence after a six-cycle reset
	initial begin
		repeat (6) @(posedge aclk);
		aresetn <= 1'h1;
		@(posedge aclk);
		t_regs();
		t_pd_rx();
		t_powerup();
		t_pcm();
		t_share();
		t_loop();
		finish_test();
	end

	// Watchdog: the run needs a few thousand cycles at most
	initial begin
		#100000;
		mismatches++;
		finish_test();
	end
endmodule

`default_nettype wire
